/* design/cad_pkg.sv */
// Purpose: shared types and constants for the address-mode decode and sequencer
// Assumes: one 8-bit data, 16-bit address bus to on-chip memory and I/O
// Notes:   opcode groups follow a high-nibble mode layout of our own choosing
package cad_pkg;

  // ----------------------------------------------------------------
  // bus carrier and sequencer types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;   // byte address
    logic [7:0]  wdata;  // write data
    logic        rd;     // read strobe, data back in same cycle
    logic        wr;     // write strobe
  } cad_bus_type;

  typedef enum logic [3:0] {
    MD_INH, MD_IMM, MD_DIR, MD_EXT, MD_IX, MD_IX1, MD_IX2, MD_REL, MD_BITB, MD_BITM
  } cad_mode_type;

  typedef enum logic [2:0] {
    ST_OPC, ST_B1, ST_B2, ST_DATA, ST_WR, ST_STOP, ST_WAIT
  } cad_state_type;

  // ----------------------------------------------------------------
  // reset values and fixed address parts
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_PC  = 16'h0100; // first fetch address
  localparam logic [7:0]  PAGE_ZERO = 8'h00;    // forced high byte
  localparam logic [7:0]  FLG_RESET = 8'hE8;    // interrupt mask set

  // condition flag positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;

  // ----------------------------------------------------------------
  // opcode groups (high nibble)
  // ----------------------------------------------------------------
  localparam logic [3:0] GRP_BITB  = 4'h0; // branch on bit
  localparam logic [3:0] GRP_BITM  = 4'h1; // bit set / clear
  localparam logic [3:0] GRP_REL   = 4'h2;
  localparam logic [3:0] GRP_RDIR  = 4'h3; // rmw direct
  localparam logic [3:0] GRP_RA    = 4'h4; // rmw on accumulator
  localparam logic [3:0] GRP_RX    = 4'h5; // rmw on index
  localparam logic [3:0] GRP_RIX1  = 4'h6;
  localparam logic [3:0] GRP_RIX   = 4'h7;
  localparam logic [3:0] GRP_CTL   = 4'h8;
  localparam logic [3:0] GRP_CTL2  = 4'h9;
  localparam logic [3:0] GRP_IMM   = 4'hA;
  localparam logic [3:0] GRP_DIR   = 4'hB;
  localparam logic [3:0] GRP_EXT   = 4'hC;
  localparam logic [3:0] GRP_IX2   = 4'hD;
  localparam logic [3:0] GRP_IX1   = 4'hE;
  localparam logic [3:0] GRP_IX    = 4'hF;

  // register/memory operations (low nibble)
  localparam logic [3:0] OP_SUB = 4'h0;
  localparam logic [3:0] OP_AND = 4'h4;
  localparam logic [3:0] OP_LDA = 4'h6;
  localparam logic [3:0] OP_STA = 4'h7;
  localparam logic [3:0] OP_EOR = 4'h8;
  localparam logic [3:0] OP_ADC = 4'h9;
  localparam logic [3:0] OP_ORA = 4'hA;
  localparam logic [3:0] OP_ADD = 4'hB;
  localparam logic [3:0] OP_LDX = 4'hE;
  localparam logic [3:0] OP_STX = 4'hF;

  // read-modify-write operations (low nibble)
  localparam logic [3:0] RM_NEG = 4'h0;
  localparam logic [3:0] RM_PRD = 4'h2; // accumulator row only
  localparam logic [3:0] RM_COM = 4'h3;
  localparam logic [3:0] RM_DEC = 4'hA;
  localparam logic [3:0] RM_INC = 4'hC;
  localparam logic [3:0] RM_TNZ = 4'hD; // flags only, no write back
  localparam logic [3:0] RM_CLR = 4'hF;

  // control opcodes
  localparam logic [7:0] OP_STOP = 8'h8E;
  localparam logic [7:0] OP_WAIT = 8'h8F;
  localparam logic [7:0] OP_TAX  = 8'h97;
  localparam logic [7:0] OP_CLC  = 8'h98;
  localparam logic [7:0] OP_SEC  = 8'h99;
  localparam logic [7:0] OP_CLI  = 8'h9A;
  localparam logic [7:0] OP_SEI  = 8'h9B;
  localparam logic [7:0] OP_TXA  = 8'h9F;

  // relative condition selects (low nibble bits 3:1), bit 0 inverts
  localparam logic [2:0] CND_ALW = 3'h0;
  localparam logic [2:0] CND_CC  = 3'h2;
  localparam logic [2:0] CND_ZC  = 3'h3;
  localparam logic [2:0] CND_NC  = 3'h5;

endpackage

/* design/cad_core.sv */
// Purpose: instruction fetch, addressing modes and operand sequencing of an 8-bit CPU
// Assumes: mem_rdata is valid in the same cycle as a read strobe on mem_req
// Notes:   one bus cycle per clock, no interrupt stacking, reduced opcode set
//
// How it works
// (RULE_01) inherent: opcode byte only, registers only
// (RULE_02) immediate: second byte is literal operand
// (RULE_03) direct: zero high byte, low byte given
// (RULE_04) extended: high then low address byte
// (RULE_05) indexed no offset: index is low byte
// (RULE_06) indexed 8-bit: unsigned nine-bit sum address
// (RULE_07) indexed 16-bit: offset high first plus index
// (RULE_08) relative: signed offset from next address
// (RULE_09) rmw: read, alter, write same place
// (RULE_10) bit set and clear: direct only
// (RULE_11) negative-zero test: no write back
// (RULE_12) bit branch: opcode, direct address, offset
// (RULE_13) tested bit always copied into carry
// (RULE_14) any bit in lowest 256 settable
// (RULE_15) register operand plus memory at address
// (RULE_16) stop halts oscillator, enables irq pin
// (RULE_17) wait halts cpu clock, enables interrupts
// (RULE_18) software avoids rmw on write-only registers
// (RULE_19) multiply: high byte index, low accumulator
// (RULE_20) 16-bit indexed sum truncated to 16
`timescale 1ns/10ps
module cad_core
  import cad_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  mem_rdata,       // read data of current cycle
  input  wire logic        ext_irq_n,       // external interrupt pin, wakes stop
  input  wire logic        int_pending,     // any interrupt request, wakes wait
  output cad_bus_type      mem_req,         // bus request, registered
  output logic [7:0]       acc_out,
  output logic [7:0]       index_out,
  output logic [7:0]       condition_flags_register,
  output logic [15:0]      pc_out,
  output logic             osc_stopped,     // oscillator halted
  output logic             cpu_clk_halted,  // cpu clock halted
  output logic             ext_irq_pin_en   // external pin armed for wake
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cad_state_type state_reg, state_next;   // sequencer step
  cad_bus_type   req_reg, req_next;       // bus request shown this cycle
  logic [15:0]   pc_reg, pc_next;         // address of next byte to fetch
  logic [7:0]    acc_reg, acc_next;
  logic [7:0]    x_reg, x_next;
  logic [7:0]    flags_reg, flags_next;   // condition flags
  logic [7:0]    opc_reg, opc_next;       // current opcode
  logic [7:0]    b1_reg, b1_next;         // first byte after opcode
  logic [7:0]    b2_reg, b2_next;         // second byte after opcode
  logic [15:0]   ea_reg, ea_next;         // held address for write back
  logic          stop_reg, stop_next;
  logic          halt_reg, halt_next;
  logic          irqen_reg, irqen_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // read request at an address
  function automatic cad_bus_type rd_req(input logic [15:0] a);
    rd_req = '{addr: a, wdata: 8'h00, rd: 1'b1, wr: 1'b0};
  endfunction

  // write request at an address
  function automatic cad_bus_type wr_req(input logic [15:0] a, input logic [7:0] d);
    wr_req = '{addr: a, wdata: d, rd: 1'b0, wr: 1'b1};
  endfunction

  // register/memory arithmetic, bit 8 is the new carry
  function automatic logic [8:0] alu(input logic [3:0] op, input logic [7:0] a,
                                     input logic [7:0] m, input logic c);
    case (op)
      OP_SUB:  alu = {1'b0, a} - {1'b0, m};
      OP_ADD:  alu = {1'b0, a} + {1'b0, m};
      OP_ADC:  alu = {1'b0, a} + {1'b0, m} + {8'h00, c};
      OP_AND:  alu = {c, a & m};
      OP_ORA:  alu = {c, a | m};
      OP_EOR:  alu = {c, a ^ m};
      default: alu = {c, m};                // loads
    endcase
  endfunction

  // single-operand modify, bit 8 is the new carry
  function automatic logic [8:0] rmw(input logic [3:0] op, input logic [7:0] v,
                                     input logic c);
    case (op)
      RM_NEG:  rmw = {(v != 8'h00), 8'h00 - v};
      RM_COM:  rmw = {1'b1, ~v};
      RM_DEC:  rmw = {c, v - 8'h01};
      RM_INC:  rmw = {c, v + 8'h01};
      RM_CLR:  rmw = {1'b0, 8'h00};
      default: rmw = {c, v};                // test passes value through
    endcase
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // the opcode is on the bus during the opcode step, held afterwards
  wire [7:0] cur_op = (state_reg == ST_OPC) ? mem_rdata : opc_reg;
  wire [3:0] grp    = cur_op[7:4];
  wire [3:0] low    = cur_op[3:0];

  // addressing mode of the current opcode
  wire cad_mode_type mode =
      (grp == GRP_BITB)                      ? MD_BITB :
      (grp == GRP_BITM || grp == GRP_RDIR)   ? MD_DIR  :
      (grp == GRP_REL)                       ? MD_REL  :
      (grp == GRP_RIX1 || grp == GRP_IX1)    ? MD_IX1  :
      (grp == GRP_RIX  || grp == GRP_IX)     ? MD_IX   :
      (grp == GRP_IMM)                       ? MD_IMM  :
      (grp == GRP_DIR)                       ? MD_DIR  :
      (grp == GRP_EXT)                       ? MD_EXT  :
      (grp == GRP_IX2)                       ? MD_IX2  : MD_INH;

  // instruction class
  wire is_bitm  = (grp == GRP_BITM);                                     // RULE_10
  wire is_rmw   = (grp == GRP_RDIR) || (grp == GRP_RIX1) || (grp == GRP_RIX);
  wire is_store = (grp >= GRP_DIR) && ((low == OP_STA) || (low == OP_STX));
  wire is_tnz   = is_rmw && (low == RM_TNZ);

  // effective addresses from the newest byte on the bus, except ea_ix (index) and ea_bit (held first byte)
  wire [15:0] ea_dir = {PAGE_ZERO, mem_rdata};                           // RULE_03
  wire [15:0] ea_ix  = {PAGE_ZERO, x_reg};                               // RULE_05
  wire [8:0]  ix1_sum = {1'b0, x_reg} + {1'b0, mem_rdata};               // RULE_06
  wire [15:0] ea_ix1 = {7'h00, ix1_sum};                                 // RULE_06
  wire [15:0] ea_ext = {b1_reg, mem_rdata};                              // RULE_04
  wire [15:0] ea_ix2 = {b1_reg, mem_rdata} + {8'h00, x_reg};             // RULE_07 RULE_20
  wire [15:0] ea_bit = {PAGE_ZERO, b1_reg};                              // RULE_12 RULE_14

  // address is known at the end of this step
  wire ea_ready = ((state_reg == ST_OPC) && (mode == MD_IX))
                || ((state_reg == ST_B1) && (mode == MD_DIR || mode == MD_IX1))
                || ((state_reg == ST_B2) && (mode == MD_EXT || mode == MD_IX2
                                             || mode == MD_BITB));
  wire [15:0] ea_val = (mode == MD_IX)   ? ea_ix  :
                       (mode == MD_DIR)  ? ea_dir :
                       (mode == MD_IX1)  ? ea_ix1 :
                       (mode == MD_EXT)  ? ea_ext :
                       (mode == MD_IX2)  ? ea_ix2 : ea_bit;

  // relative condition
  wire [2:0] cnd_sel = low[3:1];
  wire cnd_base = (cnd_sel == CND_CC) ? ~flags_reg[FLG_C] :
                  (cnd_sel == CND_ZC) ? ~flags_reg[FLG_Z] :
                  (cnd_sel == CND_NC) ? ~flags_reg[FLG_N] : 1'b1;
  wire cnd_true = cnd_base ^ low[0];

  // branch targets from the address past the branch: pc_inc for the relative branch, pc_reg for the bit branch
  wire [15:0] pc_inc    = pc_reg + 16'h0001;
  wire [15:0] rel_tgt   = pc_inc + {{8{mem_rdata[7]}}, mem_rdata};      // RULE_08
  wire [15:0] bitb_tgt  = pc_reg + {{8{b2_reg[7]}}, b2_reg};             // RULE_12

  // bit operations on the byte read from memory
  wire [7:0] bit_mask   = 8'h01 << low[3:1];
  wire [7:0] bit_result = low[0] ? (mem_rdata & ~bit_mask)
                                 : (mem_rdata | bit_mask);               // RULE_14
  wire       bit_val    = |(mem_rdata & bit_mask);
  wire       bit_hit    = bit_val ^ low[0];  // low[0] set: branch on clear

  // register/memory operation; only the index load (OP_LDX) targets index, the alu always works on the accumulator
  wire        to_x    = (low == OP_LDX);
  wire [8:0]  alu_out = alu(low, acc_reg, mem_rdata, flags_reg[FLG_C]); // RULE_15
  wire [7:0]  rm_res  = to_x ? mem_rdata : alu_out[7:0];
  wire        alu_arith = (low == OP_SUB) || (low == OP_ADD) || (low == OP_ADC);

  // modify path: inherent rows use registers, others the memory byte
  wire [7:0]  rmw_src = (grp == GRP_RA) ? acc_reg :
                        (grp == GRP_RX) ? x_reg : mem_rdata;             // RULE_01
  wire [8:0]  rmw_out = rmw(low, rmw_src, flags_reg[FLG_C]);
  wire [15:0] product = acc_reg * x_reg;                                 // RULE_19

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    req_next   = rd_req(pc_reg);
    pc_next    = pc_reg;
    acc_next   = acc_reg;
    x_next     = x_reg;
    flags_next = flags_reg;
    opc_next   = opc_reg;
    b1_next    = b1_reg;
    b2_next    = b2_reg;
    ea_next    = ea_reg;
    stop_next  = stop_reg;
    halt_next  = halt_reg;
    irqen_next = irqen_reg;
    case (state_reg)
      // opcode on the bus
      ST_OPC: begin
        opc_next = mem_rdata;
        pc_next  = pc_inc;
        if (mode == MD_INH) begin
          // one byte, no operand address
          req_next   = rd_req(pc_inc);                                   // RULE_01
          state_next = ST_OPC;
          if (grp == GRP_RA && low == RM_PRD) begin
            x_next   = product[15:8];                                    // RULE_19
            acc_next = product[7:0];                                     // RULE_19
            flags_next[FLG_C] = 1'b0;
          end else if (grp == GRP_RA || grp == GRP_RX) begin
            // register modify, written back to the same register except for the test (RM_TNZ)
            if (grp == GRP_RA && low != RM_TNZ) acc_next = rmw_out[7:0]; // RULE_09
            if (grp == GRP_RX && low != RM_TNZ) x_next = rmw_out[7:0];   // RULE_09
            flags_next[FLG_C] = rmw_out[8];
            flags_next[FLG_N] = rmw_out[7];
            flags_next[FLG_Z] = (rmw_out[7:0] == 8'h00);
          end else if (mem_rdata == OP_STOP) begin
            stop_next  = 1'b1;                                           // RULE_16
            irqen_next = 1'b1;                                           // RULE_16
            req_next   = '0;
            state_next = ST_STOP;
          end else if (mem_rdata == OP_WAIT) begin
            halt_next  = 1'b1;                                           // RULE_17
            flags_next[FLG_I] = 1'b0;                                    // RULE_17
            req_next   = '0;
            state_next = ST_WAIT;
          end else if (mem_rdata == OP_TAX) begin
            x_next = acc_reg;
          end else if (mem_rdata == OP_TXA) begin
            acc_next = x_reg;
          end else if (mem_rdata == OP_CLC || mem_rdata == OP_SEC) begin
            flags_next[FLG_C] = mem_rdata[0];
          end else if (mem_rdata == OP_CLI || mem_rdata == OP_SEI) begin
            flags_next[FLG_I] = mem_rdata[0];
          end
        end else if (ea_ready) begin
          // indexed without offset: address known now
          ea_next    = ea_val;
          req_next   = is_store ? wr_req(ea_val, (low == OP_STX) ? x_reg : acc_reg) // RULE_05
                                : rd_req(ea_val);
          state_next = is_store ? ST_WR : ST_DATA;
        end else begin
          req_next   = rd_req(pc_inc);
          state_next = ST_B1;
        end
      end
      // first byte after opcode on the bus
      ST_B1: begin
        b1_next = mem_rdata;
        pc_next = pc_inc;
        if (mode == MD_IMM) begin
          // literal operand against accumulator or index
          if (to_x) x_next = rm_res;                                     // RULE_02
          else if (low != OP_STA && low != OP_STX) acc_next = rm_res;    // RULE_02
          if (alu_arith) flags_next[FLG_C] = alu_out[8];
          flags_next[FLG_N] = rm_res[7];
          flags_next[FLG_Z] = (rm_res == 8'h00);
          req_next   = rd_req(pc_inc);
          state_next = ST_OPC;
        end else if (mode == MD_REL) begin
          pc_next    = cnd_true ? rel_tgt : pc_inc;                      // RULE_08
          req_next   = rd_req(cnd_true ? rel_tgt : pc_inc);              // RULE_08
          state_next = ST_OPC;
        end else if (ea_ready) begin
          ea_next    = ea_val;
          req_next   = is_store ? wr_req(ea_val, (low == OP_STX) ? x_reg : acc_reg)
                                : rd_req(ea_val);
          state_next = is_store ? ST_WR : ST_DATA;
        end else begin
          req_next   = rd_req(pc_inc);
          state_next = ST_B2;
        end
      end
      // second byte after opcode on the bus
      ST_B2: begin
        b2_next    = mem_rdata;
        pc_next    = pc_inc;
        ea_next    = ea_val;
        req_next   = is_store ? wr_req(ea_val, (low == OP_STX) ? x_reg : acc_reg)
                              : rd_req(ea_val);
        state_next = is_store ? ST_WR : ST_DATA;
      end
      // operand byte on the bus
      ST_DATA: begin
        req_next   = rd_req(pc_reg);
        state_next = ST_OPC;
        if (mode == MD_BITB) begin
          flags_next[FLG_C] = bit_val;                                   // RULE_13
          pc_next  = bit_hit ? bitb_tgt : pc_reg;                        // RULE_12
          req_next = rd_req(bit_hit ? bitb_tgt : pc_reg);                // RULE_12
        end else if (is_bitm) begin
          req_next   = wr_req(ea_reg, bit_result);                       // RULE_10 RULE_09
          state_next = ST_WR;
        end else if (is_rmw) begin
          flags_next[FLG_C] = rmw_out[8];
          flags_next[FLG_N] = rmw_out[7];
          flags_next[FLG_Z] = (rmw_out[7:0] == 8'h00);
          if (!is_tnz) begin
            req_next   = wr_req(ea_reg, rmw_out[7:0]);                   // RULE_09
            state_next = ST_WR;
          end                                                            // RULE_11
        end else begin
          if (to_x) x_next = rm_res;                                     // RULE_15
          else acc_next = rm_res;                                        // RULE_15
          if (alu_arith) flags_next[FLG_C] = alu_out[8];
          flags_next[FLG_N] = rm_res[7];
          flags_next[FLG_Z] = (rm_res == 8'h00);
        end
      end
      // write on the bus, then fetch resumes
      ST_WR: begin
        req_next   = rd_req(pc_reg);
        state_next = ST_OPC;
      end
      // oscillator stopped until the external pin is seen low
      ST_STOP: begin
        req_next = '0;
        if (!ext_irq_n) begin
          stop_next  = 1'b0;
          irqen_next = 1'b0;
          req_next   = rd_req(pc_reg);
          state_next = ST_OPC;
        end
      end
      // cpu clock halted until an interrupt request
      ST_WAIT: begin
        req_next = '0;
        if (int_pending) begin
          halt_next  = 1'b0;
          req_next   = rd_req(pc_reg);
          state_next = ST_OPC;
        end
      end
      default: begin
        req_next   = rd_req(pc_reg);
        state_next = ST_OPC;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset starts a fetch at the reset address
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_OPC;
      req_reg   <= '{addr: RESET_PC, wdata: 8'h00, rd: 1'b1, wr: 1'b0};
      pc_reg    <= RESET_PC;
      acc_reg   <= 8'h00;
      x_reg     <= 8'h00;
      flags_reg <= FLG_RESET;
      opc_reg   <= 8'h00;
      b1_reg    <= 8'h00;
      b2_reg    <= 8'h00;
      ea_reg    <= 16'h0000;
      stop_reg  <= 1'b0;
      halt_reg  <= 1'b0;
      irqen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_reg   <= req_next;
      pc_reg    <= pc_next;
      acc_reg   <= acc_next;
      x_reg     <= x_next;
      flags_reg <= flags_next;
      opc_reg   <= opc_next;
      b1_reg    <= b1_next;
      b2_reg    <= b2_next;
      ea_reg    <= ea_next;
      stop_reg  <= stop_next;
      halt_reg  <= halt_next;
      irqen_reg <= irqen_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign mem_req                  = req_reg;
  assign acc_out                  = acc_reg;
  assign index_out                = x_reg;
  assign condition_flags_register = flags_reg;
  assign pc_out                   = pc_reg;
  assign osc_stopped              = stop_reg;
  assign cpu_clk_halted           = halt_reg;
  assign ext_irq_pin_en           = irqen_reg;

endmodule

/* tb/cad_mem.sv */
// Purpose: on-chip memory and I/O seen from the cpu bus
// Assumes: reads answer in the strobe cycle, writes land at the edge
// Notes:   the bench loads the byte array directly
`timescale 1ns/10ps
module cad_mem
  import cad_pkg::*;
(
  input wire logic        clk,
  input wire cad_bus_type req,
  output logic [7:0]      rdata
);
  logic [7:0] m [0:65535];  // byte array
  // idle lines show the inverse byte, so a stale read cannot pass
  assign rdata = req.rd ? m[req.addr] : ~m[req.addr];
  // write on the strobe edge
  always @(posedge clk)
    if (req.wr) m[req.addr] <= req.wdata;
endmodule

/* tb/cad_core_assertions.sv */
// Purpose: bus-level checks on addressing and low-power entry
// Assumes: code fetched only from 0100..01AF, no data read lands there
// Notes:   opcode cycles are spotted by byte value in that window
`timescale 1ns/10ps
module cad_core_assertions
  import cad_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  mem_rdata,
  input wire cad_bus_type mem_req,
  input wire logic [7:0]  index_out,
  input wire logic [7:0]  condition_flags_register,
  input wire logic        osc_stopped,
  input wire logic        cpu_clk_halted,
  input wire logic        ext_irq_pin_en
);
  wire [15:0] a = mem_req.addr;  // bus address
  wire [7:0]  d = mem_rdata;     // read data
  wire        p = mem_req.rd && a >= 16'h0100 && a < 16'h01B0;  // code read
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_tnz; p && d == 8'h3D |-> ##2 mem_req.rd && a[15:8] == PAGE_ZERO ##1 !mem_req.wr;
  endproperty
  a_tnz: assert property (p_tnz) else $error("test wrote back");
  property p_rmw; p && d == 8'h3C |-> ##2 mem_req.rd ##1 mem_req.wr && a == $past(a) &&
    mem_req.wdata == $past(d) + 8'h01; endproperty
  a_rmw: assert property (p_rmw) else $error("rmw write bad");
  property p_bitset; p && d == 8'h16 |-> ##2 a[15:8] == PAGE_ZERO ##1 mem_req.wr &&
    a == $past(a) && mem_req.wdata == ($past(d) | 8'h08); endproperty
  a_bitset: assert property (p_bitset) else $error("bit set bad");
  property p_bitbr; p && d == 8'h06 |-> ##4 condition_flags_register[FLG_C] == $past(d[3]) &&
    a == $past(a, 4) + 16'h0003 + ($past(d[3]) ? {{8{$past(d[7], 2)}}, $past(d, 2)} : 16'h0000);
  endproperty
  a_bitbr: assert property (p_bitbr) else $error("bit branch bad");
  property p_rel; p && d == 8'h20 |-> ##2 a == $past(a, 2) + 16'h0002 + {{8{$past(d[7])}}, $past(d)};
  endproperty
  a_rel: assert property (p_rel) else $error("branch target bad");
  property p_ix2; p && d == 8'hD7 |-> ##3 mem_req.wr && a == {$past(d, 2), $past(d)} +
    {8'h00, index_out}; endproperty
  a_ix2: assert property (p_ix2) else $error("ix2 address bad");
  property p_stop; p && d == OP_STOP |-> ##1 osc_stopped && ext_irq_pin_en && mem_req == '0;
  endproperty
  a_stop: assert property (p_stop) else $error("stop entry bad");
  property p_wait; p && d == OP_WAIT |-> ##1 cpu_clk_halted && !condition_flags_register[FLG_I];
  endproperty
  a_wait: assert property (p_wait) else $error("wait entry bad");
endmodule

/* tb/tb.sv */
// Purpose: runs a short program on cad_core against a bench memory model
// Assumes: program sits at the reset fetch address
// Notes:   operands from an lfsr seeded with 7, index kept off opcode values
`timescale 1ns/10ps
module tb;
  import cad_pkg::*;
  logic        clk, rst, ext_irq_n, int_pending, stp, hlt, pen;
  logic [7:0]  rdata, acc, idx, flags, lf, xv, s;
  logic [15:0] pr, pc;
  cad_bus_type req;
  int          failures, check_count, k;
  logic [7:0]  img [0:65535];  // model memory
  logic [7:0]  prg [$];        // program bytes
  cad_core i_dut (.clk(clk), .rst(rst), .mem_rdata(rdata), .ext_irq_n(ext_irq_n),
    .int_pending(int_pending), .mem_req(req), .acc_out(acc), .index_out(idx), .pc_out(pc),
    .condition_flags_register(flags), .osc_stopped(stp), .cpu_clk_halted(hlt),
    .ext_irq_pin_en(pen));
  cad_mem i_mem (.clk(clk), .req(req), .rdata(rdata));
  function automatic logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog, far past the fewer than a hundred cycles needed
  initial begin
    #100000;
    failures++;
    end_sim();
  end
  initial begin
    {rst, ext_irq_n, int_pending, lf} = {3'b110, 8'h07};
    for (int i = 0; i < 65536; i++) img[i] = rnd();
    xv = 8'hC8 | (rnd() & 8'h30);
    // rmw only on plain memory bytes
    prg = '{8'hAE, xv, 8'hB6, 8'h10, 8'hE7, 8'hF0, 8'hD7, 8'hFF, 8'hF0, 8'h3C, 8'h11,
      8'h3D, 8'h12, 8'h16, 8'h13, 8'h11, 8'h14, 8'h06, 8'h13, 8'h02, 8'h4C, 8'h4C, 8'h24,
      8'h05, 8'hC6, 8'h23, 8'h45, 8'hFB, 8'h42, 8'hFF, 8'hC7, 8'h30, 8'h00, 8'hCF, 8'h30, 8'h01,
      8'h8E, 8'h8F, 8'h20, 8'hFE};
    foreach (prg[i]) img[16'h0100 + i] = prg[i];
    for (int i = 0; i < 65536; i++) i_mem.m[i] = img[i];
    s = img[16'h0010];
    img[{8'h00, xv} + 16'h00F0] = s;
    img[{8'h00, xv} + 16'hFFF0] = s;
    img[16'h0011] = img[16'h0011] + 8'h01;
    img[16'h0013] = img[16'h0013] | 8'h08;
    img[16'h0014] = img[16'h0014] & 8'hFE;
    s = img[16'h2345] + img[{8'h00, xv}];
    pr = s * xv;
    img[{8'h00, pr[15:8]}] = pr[15:8];
    img[16'h3000] = pr[7:0];
    img[16'h3001] = pr[15:8];
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    for (k = 0; k < 300 && stp !== 1'b1; k++) #10;
    chk("stop", 8'h03, {6'h00, stp, pen});
    chk("stop pc", 8'h25, pc[7:0]);
    #10 ext_irq_n = 1'b0;
    #10 ext_irq_n = 1'b1;
    $display("test stop done");
    for (k = 0; k < 300 && hlt !== 1'b1; k++) #10;
    chk("wait", 8'h02, {6'h00, hlt, flags[FLG_I]});
    chk("wait pc", 8'h26, pc[7:0]);
    #10 int_pending = 1'b1;
    #10 int_pending = 1'b0;
    $display("test wait done");
    #200;
    chk("acc", pr[7:0], acc);
    chk("index", pr[15:8], idx);
    chk("carry", 8'h00, {7'h00, flags[FLG_C]});
    chk("awake", 8'h00, {5'h00, stp, pen, hlt});
    for (int i = 0; i < 16'h4000; i++) chk("mem", img[i], i_mem.m[i]);
    $display("test image done");
    end_sim();
  end
endmodule
bind cad_core cad_core_assertions i_chk (.clk(clk), .rst(rst), .mem_rdata(mem_rdata),
  .mem_req(mem_req), .index_out(index_out), .condition_flags_register(condition_flags_register),
  .osc_stopped(osc_stopped), .cpu_clk_halted(cpu_clk_halted), .ext_irq_pin_en(ext_irq_pin_en));
